// ### core/shp_consts.svh
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH

// ==========================================================
// Register offsets (seven-bit register addresses)
`define SHP_ADDR_STATUS 7'h00
`define SHP_ADDR_THRESH 7'h06
`define SHP_ADDR_MODE 7'h10
`define SHP_ADDR_CLKCTL 7'h4B
`define SHP_ADDR_HOLD 7'h5F
`define SHP_ADDR_FIFO 7'h60
`define SHP_ADDR_LAST 7'h7F

// ==========================================================
// Field positions
`define SHP_CLKEN_BIT 7
`define SHP_FLUSH_BIT 15
`define SHP_FIFO_INT_BIT 7
`define SHP_THRESH_LSB 8

// ==========================================================
// Mode register values and reset values
`define SHP_MODE_STANDBY 2'h0
`define SHP_MODE_PROGRAM 2'h1
`define SHP_MODE_NORMAL 2'h2
`define SHP_MODE_RESET 16'h0000
`define SHP_CLKCTL_RESET 16'h0000
`define SHP_THRESH_RESET 6'h00

// ==========================================================
// FIFO sizing
`define SHP_FIFO_BYTES 128
`define SHP_PKT_MAX_BYTES 32

`endif

// ### core/shp_pkg.sv
package shp_pkg;
	// Operating mode state, one-hot
	typedef enum logic [2:0] {
		SHP_STANDBY = 3'b001,
		SHP_PROGRAM = 3'b010,
		SHP_NORMAL = 3'b100
	} shp_mode_t;
endpackage

// ### core/shp_xfer_if.sv
// Carries serial-side events and words between the link clock and ref_clk
interface shp_xfer_if;
	logic [6:0] addr;
	logic addr_tgl;
	logic half_tgl;
	logic word_tgl;
	logic word_wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport link(output addr, addr_tgl, half_tgl, word_tgl, word_wr, wdata, input rdata);
	modport core(input addr, addr_tgl, half_tgl, word_tgl, word_wr, wdata, output rdata);
endinterface

// ### core/shp_spi_link.sv
// ==========================================================
// Serial shifter on the host clock; chip select high clears the frame state
module shp_spi_link (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic rst_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	shp_xfer_if.link xf
);
	logic in_data;
	logic is_read;
	logic [3:0] bidx;
	logic [14:0] shreg;
	logic [14:0] tx;

	// Bit and byte counters; a partial word dies with chip select
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			in_data <= 1'b0; // RULE_25
			is_read <= 1'b0;
			bidx <= 4'h0;
			shreg <= 15'h0000;
		end else begin
			shreg <= {shreg[13:0], mosi}; // RULE_03 RULE_05
			if (!in_data && bidx == 4'h7) begin
				in_data <= 1'b1;
				bidx <= 4'h0;
				is_read <= ~mosi; // RULE_07
			end else begin
				bidx <= bidx + 4'h1;
			end
		end
	end

	// Events toward ref_clk; toggles survive chip select so no false edge
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			xf.addr <= 7'h00;
			xf.addr_tgl <= 1'b0;
			xf.half_tgl <= 1'b0;
			xf.word_tgl <= 1'b0;
			xf.word_wr <= 1'b0;
			xf.wdata <= 16'h0000;
		end else if (!cs_n) begin
			// Address known after its seventh bit, early enough to prefetch
			if (!in_data && bidx == 4'h6) begin
				xf.addr <= {shreg[5:0], mosi}; // RULE_06
				xf.addr_tgl <= ~xf.addr_tgl;
			end
			if (in_data && is_read && bidx == 4'h7)
				xf.half_tgl <= ~xf.half_tgl;
			if (in_data && bidx == 4'hF) begin
				xf.wdata <= {shreg, mosi}; // RULE_08
				xf.word_wr <= ~is_read;
				xf.word_tgl <= ~xf.word_tgl;
			end
		end
	end

	// Read data leaves on falling edges; rdata is stable for several ref cycles
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			miso_o <= 1'b0;
			miso_oe <= 1'b0; // RULE_04
			tx <= 15'h0000;
		end else if (in_data && is_read) begin
			miso_oe <= 1'b1; // RULE_04
			if (bidx == 4'h0) begin
				miso_o <= xf.rdata[15]; // RULE_03 RULE_05
				tx <= xf.rdata[14:0];
			end else begin
				miso_o <= tx[14];
				tx <= {tx[13:0], 1'b0};
			end
		end
	end
endmodule

// ### core/shp_fifo.sv
`include "shp_consts.svh"

// ==========================================================
// Byte FIFO that takes whole packets and gives 16-bit words
module shp_fifo #(
	parameter int DEPTH = `SHP_FIFO_BYTES,
	parameter int PKT_MAX = `SHP_PKT_MAX_BYTES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [5:0] push_len,
	input wire logic [8*PKT_MAX-1:0] push_data,
	input wire logic pop,
	output logic push_ok,
	output logic [7:0] count,
	output logic [15:0] head0,
	output logic [15:0] head1
);
	logic [7:0] mem [DEPTH];
	logic [6:0] wr_ptr;
	logic [6:0] rd_ptr;
	logic do_pop;

	// Whole packet or nothing keeps packets intact
	assign push_ok = push && (count + 8'(push_len) <= 8'(DEPTH)); // RULE_20
	assign do_pop = pop && count >= 8'h02;
	assign head0 = {mem[rd_ptr], mem[rd_ptr + 7'h01]};
	assign head1 = {mem[rd_ptr + 7'h02], mem[rd_ptr + 7'h03]};

	// Packet bytes land in order, first byte from the top of push_data
	// One process owns the array, so no byte has two writers
	always_ff @(posedge clk) begin
		if (push_ok && !flush) begin
			for (int i = 0; i < PKT_MAX; i++) begin
				if (6'(i) < push_len)
					mem[wr_ptr + 7'(i)] <= push_data[8*(PKT_MAX-i)-1 -: 8]; // RULE_17 RULE_19
			end
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 7'h00;
			rd_ptr <= 7'h00;
			count <= 8'h00;
		end else if (flush) begin
			wr_ptr <= 7'h00;
			rd_ptr <= 7'h00;
			count <= 8'h00;
		end else begin
			if (push_ok)
				wr_ptr <= wr_ptr + 7'(push_len);
			if (do_pop)
				rd_ptr <= rd_ptr + 7'h02; // RULE_23
			count <= count + (push_ok ? 8'(push_len) : 8'h00) - (do_pop ? 8'h02 : 8'h00);
		end
	end
endmodule

// ### core/shp_top.sv
// Operation
// RULE_01: Device is only ever a slave on chip select, MOSI, MISO, SCLK.
// RULE_02: Host frames each transaction with one low period of chip select.
// RULE_03: MOSI sampled on SCLK rise, MISO changes on fall, host samples on rise.
// RULE_04: MISO stays undriven until a read direction bit arrives.
// RULE_05: Every byte goes most significant bit first.
// RULE_06: First byte is seven address bits, top first, then direction bit.
// RULE_07: Direction bit one means write, zero means read.
// RULE_08: Data moves as 16-bit words, upper byte then lower byte.
// RULE_09: Host keeps serial clock at or below the maximum rate.
// RULE_10: Address advances after each word except at 0x5F, 0x60, 0x7F.
// RULE_11: Reset leaves standby mode with mode register zero.
// RULE_12: Mode changes only while sample clock enable is set.
// RULE_13: Mode one means program; clock enable and write in either order.
// RULE_14: Mode two starts normal sampling, zero returns to standby.
// RULE_15: Status write 0x00FF clears flags, 0x80FF also empties FIFO.
// RULE_16: Clock enable cleared outside standby leaves modes stuck.
// RULE_17: A 128-byte FIFO holds samples from either or both slots.
// RULE_18: Both slots feed the FIFO only with equal averaging factors.
// RULE_19: Each packet holds one whole sample per enabled slot.
// RULE_20: A packet is stored only if it fits whole, else dropped.
// RULE_21: Status upper byte reads the current FIFO byte count.
// RULE_22: FIFO flag rises when stored data passes the configured level.
// RULE_23: Each FIFO word read gives the next word and frees it.
// RULE_24: FIFO flag clears on any FIFO read, sets again on later write.
// RULE_25: Chip select rising mid-word discards it and resets counters.
// RULE_26: Host reads the FIFO in whole packets only.
`include "shp_consts.svh"

module shp_top #(
	parameter int PKT_MAX = `SHP_PKT_MAX_BYTES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	input wire logic pkt_valid,
	input wire logic [5:0] pkt_len,
	input wire logic [8*PKT_MAX-1:0] pkt_data,
	output shp_pkg::shp_mode_t op_mode,
	output logic fifo_int
);
	// ==========================================================
	// Link side
	shp_xfer_if xf ();

	// The port only answers; it never starts a transfer
	shp_spi_link u_link ( // RULE_01
		.sclk(sclk),
		.cs_n(cs_n),
		.rst_n(rst_n),
		.mosi(mosi),
		.miso_o(miso_o),
		.miso_oe(miso_oe),
		.xf(xf.link)
	);

	// ==========================================================
	// Event crossing: two flip-flops per toggle, then an edge flop
	logic [2:0] tgl_in;
	logic [2:0] tgl_s1;
	logic [2:0] tgl_s2;
	logic [2:0] tgl_s3;
	logic [2:0] tgl_ev;

	assign tgl_in = {xf.word_tgl, xf.half_tgl, xf.addr_tgl};

	generate
		for (genvar g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					tgl_s1[g] <= 1'b0;
					tgl_s2[g] <= 1'b0;
					tgl_s3[g] <= 1'b0;
				end else begin
					tgl_s1[g] <= tgl_in[g];
					tgl_s2[g] <= tgl_s1[g];
					tgl_s3[g] <= tgl_s2[g];
				end
			end
			assign tgl_ev[g] = tgl_s2[g] ^ tgl_s3[g];
		end
	endgenerate

	logic ev_addr;
	logic ev_half;
	logic ev_word;

	assign ev_addr = tgl_ev[0];
	assign ev_half = tgl_ev[1];
	assign ev_word = tgl_ev[2];

	// ==========================================================
	// Address walk
	function automatic logic [6:0] next_addr(input logic [6:0] a);
		if (a == `SHP_ADDR_HOLD || a == `SHP_ADDR_FIFO || a == `SHP_ADDR_LAST)
			return a; // RULE_10
		return a + 7'h01; // RULE_10
	endfunction

	logic [6:0] cur_addr;

	// Word events walk the address; addr and wdata are held by the link side
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			cur_addr <= 7'h00;
		else if (ev_addr)
			cur_addr <= xf.addr;
		else if (ev_word)
			cur_addr <= next_addr(cur_addr); // RULE_10
	end

	// ==========================================================
	// Registers
	logic [1:0] mode_reg;
	logic [15:0] clkctl_reg;
	logic [5:0] thresh_reg;
	logic wr_ev;
	logic rd_ev;

	assign wr_ev = ev_word && xf.word_wr;
	assign rd_ev = ev_word && !xf.word_wr;

	// Operating mode target
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			mode_reg <= 2'(`SHP_MODE_RESET); // RULE_11
		else if (wr_ev && cur_addr == `SHP_ADDR_MODE)
			mode_reg <= xf.wdata[1:0];
	end

	// Sample clock control; bit 7 gates the mode machine
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			clkctl_reg <= `SHP_CLKCTL_RESET;
		else if (wr_ev && cur_addr == `SHP_ADDR_CLKCTL)
			clkctl_reg <= xf.wdata;
	end

	// FIFO interrupt level in words
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			thresh_reg <= `SHP_THRESH_RESET;
		else if (wr_ev && cur_addr == `SHP_ADDR_THRESH)
			thresh_reg <= xf.wdata[`SHP_THRESH_LSB +: 6];
	end

	// ==========================================================
	// Mode machine
	logic sample_clock_enable;

	assign sample_clock_enable = clkctl_reg[`SHP_CLKEN_BIT];

	// Without the sample clock the machine freezes, even for standby
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_mode <= shp_pkg::SHP_STANDBY; // RULE_11
		end else if (sample_clock_enable) begin // RULE_12 RULE_16
			unique case (mode_reg)
				`SHP_MODE_STANDBY: op_mode <= shp_pkg::SHP_STANDBY; // RULE_14
				`SHP_MODE_PROGRAM: op_mode <= shp_pkg::SHP_PROGRAM; // RULE_13
				`SHP_MODE_NORMAL: op_mode <= shp_pkg::SHP_NORMAL; // RULE_14
				default: op_mode <= op_mode;
			endcase
		end
	end

	// ==========================================================
	// FIFO
	logic fifo_flush;
	logic fifo_push;
	logic fifo_pop;
	logic push_ok;
	logic [7:0] fifo_count;
	logic [15:0] head0;
	logic [15:0] head1;

	assign fifo_flush = wr_ev && cur_addr == `SHP_ADDR_STATUS && xf.wdata[`SHP_FLUSH_BIT]; // RULE_15
	assign fifo_push = pkt_valid && op_mode == shp_pkg::SHP_NORMAL;
	assign fifo_pop = rd_ev && cur_addr == `SHP_ADDR_FIFO; // RULE_23

	shp_fifo #(
		.DEPTH(`SHP_FIFO_BYTES),
		.PKT_MAX(PKT_MAX)
	) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.push(fifo_push),
		.push_len(pkt_len),
		.push_data(pkt_data),
		.pop(fifo_pop),
		.push_ok(push_ok),
		.count(fifo_count),
		.head0(head0),
		.head1(head1)
	);

	// ==========================================================
	// FIFO level flag
	logic [8:0] fill_after;
	logic level_hit;
	logic flag_clr;

	assign fill_after = {1'b0, fifo_count} + {3'h0, pkt_len};
	assign level_hit = push_ok && !fifo_flush && fill_after[8:1] > {2'h0, thresh_reg};
	assign flag_clr = fifo_pop || (wr_ev && cur_addr == `SHP_ADDR_STATUS
		&& xf.wdata[`SHP_FIFO_INT_BIT]);

	// A write that lands as the flag is cleared still sets it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fifo_int <= 1'b0;
		else if (level_hit)
			fifo_int <= 1'b1; // RULE_22 RULE_24
		else if (flag_clr)
			fifo_int <= 1'b0; // RULE_24 RULE_15
	end

	// ==========================================================
	// Read data prefetch
	function automatic logic [15:0] read_mux(input logic [6:0] a, input logic [15:0] fw);
		unique case (a)
			`SHP_ADDR_STATUS: return {fifo_count, fifo_int, 7'h00}; // RULE_21
			`SHP_ADDR_THRESH: return {2'h0, thresh_reg, 8'h00};
			`SHP_ADDR_MODE: return {14'h0000, mode_reg};
			`SHP_ADDR_CLKCTL: return clkctl_reg;
			`SHP_ADDR_FIFO: return fw; // RULE_23
			default: return 16'h0000;
		endcase
	endfunction

	// Next word is fetched mid-word, before the current FIFO word is freed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			xf.rdata <= 16'h0000;
		else if (ev_addr)
			xf.rdata <= read_mux(xf.addr, head0);
		else if (ev_half)
			xf.rdata <= read_mux(next_addr(cur_addr), head1); // RULE_10
	end
endmodule

// ### dv/shp_host_model.sv
// ==========================================================
// Host side SPI master: clock idles low and stands still between frames
module shp_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 32;
	logic [15:0] wdat [8];
	logic [15:0] rdat [8];
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// One bit out on MOSI, MISO taken at the rising edge
	task automatic bit_x(input logic b, input int extra, output logic r);
		mosi = b;
		#HALF sclk = 1'b1;
		r = miso_oe ? miso_o : 1'bz;
		#(HALF + extra) sclk = 1'b0;
	endtask
	// Header, whole words, then an optional cut; the long eighth bit gives the core time
	task automatic frame(input logic [6:0] a, input logic wr, input int n, input int cut);
		logic r;
		logic [7:0] hdr;
		hdr = {a, wr};
		cs_n = 1'b0;
		#(HALF + 3);
		for (int i = 7; i >= 0; i--) begin
			bit_x(hdr[i], i == 0 ? 4 * HALF : 0, r);
		end
		for (int k = 0; k < 16 * n + cut; k++) begin
			bit_x(wdat[k / 16][15 - k % 16], 0, r);
			rdat[k / 16][15 - k % 16] = r;
		end
		#HALF cs_n = 1'b1;
		mosi = ~mosi;
		#(8 * HALF);
	endtask
endmodule

// ### dv/shp_top_chk.sv
module shp_top_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic pkt_valid,
	input wire shp_pkg::shp_mode_t op_mode,
	input wire logic fifo_int
);
	logic [4:0] bit_cnt;
	logic dir_bit;
	logic [3:0] idle_cnt;
	// ==========================================================
	// Helpers: bits seen in this frame, direction bit, idle cycles
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n)
			bit_cnt <= 5'h00;
		else if (bit_cnt != 5'h1F)
			bit_cnt <= bit_cnt + 5'h01;
	end
	always_ff @(posedge sclk) begin
		if (bit_cnt == 5'h07)
			dir_bit <= mosi;
	end
	// Saturates so a long idle never wraps back into range
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			idle_cnt <= 4'hF;
		else if (!cs_n)
			idle_cnt <= 4'h0;
		else if (idle_cnt != 4'hF)
			idle_cnt <= idle_cnt + 4'h1;
	end
	// ==========================================================
	// Properties
	property p_oe_idle;
		@(posedge ref_clk) disable iff (!rst_n) cs_n |-> !miso_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("MISO driven while deselected");
	property p_oe_hdr;
		@(posedge sclk) disable iff (!rst_n) (bit_cnt < 5'h08 || dir_bit) |-> !miso_oe;
	endproperty
	a_oe_hdr: assert property (p_oe_hdr) else $error("MISO driven outside a read");
	property p_oe_rd;
		@(posedge sclk) disable iff (!rst_n) (bit_cnt >= 5'h08 && !dir_bit) |-> miso_oe;
	endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("MISO not driven in read");
	property p_miso_hold;
		@(posedge ref_clk) disable iff (!rst_n) (sclk && $past(sclk)) |-> $stable(miso_o);
	endproperty
	a_miso_hold: assert property (p_miso_hold) else $error("MISO moved while clock high");
	property p_mode_rst;
		@(posedge ref_clk) disable iff (!rst_n) $rose(rst_n) |-> op_mode == shp_pkg::SHP_STANDBY;
	endproperty
	a_mode_rst: assert property (p_mode_rst) else $error("mode not standby after reset");
	property p_mode_quiet;
		@(posedge ref_clk) disable iff (!rst_n) cs_n [*8] |=> $stable(op_mode);
	endproperty
	a_mode_quiet: assert property (p_mode_quiet) else $error("mode changed without access");
	property p_mode_hot;
		@(posedge ref_clk) disable iff (!rst_n) $onehot(op_mode);
	endproperty
	a_mode_hot: assert property (p_mode_hot) else $error("mode not one-hot");
	property p_int_rise;
		@(posedge ref_clk) disable iff (!rst_n)
			$rose(fifo_int) |-> $past(pkt_valid) && $past(op_mode) == shp_pkg::SHP_NORMAL;
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("flag rose without packet");
	property p_int_fall;
		@(posedge ref_clk) disable iff (!rst_n) $fell(fifo_int) |-> idle_cnt < 4'h8;
	endproperty
	a_int_fall: assert property (p_int_fall) else $error("flag fell without access");
endmodule

bind shp_top shp_top_chk shp_top_chk_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
	.miso_o(miso_o), .miso_oe(miso_oe), .pkt_valid(pkt_valid), .op_mode(op_mode),
	.fifo_int(fifo_int)
);

// ### dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_n, sclk, cs_n, mosi, miso_o, miso_oe, pkt_valid, fifo_int;
	logic [5:0] pkt_len;
	logic [255:0] pkt_data;
	shp_pkg::shp_mode_t op_mode;
	int n_errors, checks, cnt, thr;
	logic flag, nrm;
	logic [31:0] lfsr;
	logic [7:0] q [$];
	logic [7:0] b;
	logic [15:0] v;
	shp_top shp_top_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe), .pkt_valid(pkt_valid), .pkt_len(pkt_len),
		.pkt_data(pkt_data), .op_mode(op_mode), .fifo_int(fifo_int)
	);
	shp_host_model shp_host_model_inst (
		.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe)
	);
	// ==========================================================
	// Clock, watchdog, helpers
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#1000000;
		n_errors++;
		results();
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// A packet is stored only whole and only in normal mode
	function automatic logic takes(input logic n, input int c, input int l);
		return n && c + l <= 128;
	endfunction
	function automatic logic [15:0] stat(input int c, input logic f);
		return {c[7:0], f, 7'h00};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		shp_host_model_inst.wdat[0] = d;
		shp_host_model_inst.frame(a, 1'b1, 1, 0);
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		shp_host_model_inst.frame(a, 1'b0, 1, 0);
		d = shp_host_model_inst.rdat[0];
	endtask
	// Offer one packet of random bytes for one cycle; slots share one rate
	task automatic push(input int len);
		logic ok;
		@(negedge ref_clk);
		ok = takes(nrm, cnt, len);
		pkt_len = 6'(len);
		for (int i = 0; i < 32; i++) begin
			lfsr = nxt(lfsr);
			pkt_data[255 - 8 * i -: 8] = lfsr[7:0];
			if (ok && i < len)
				q.push_back(lfsr[7:0]);
		end
		pkt_valid = 1'b1;
		if (ok)
			cnt = cnt + len;
		if (ok && cnt / 2 > thr)
			flag = 1'b1;
		@(negedge ref_clk);
		pkt_valid = 1'b0;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		pkt_valid = 1'b0;
		pkt_len = 6'h00;
		pkt_data = '0;
		lfsr = 32'h568F;
		cnt = 0;
		thr = 3;
		flag = 1'b0;
		nrm = 1'b0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		rd(7'h10, v);
		check(v, 32'h0000);
		wr(7'h10, 16'h0001);
		check(op_mode, shp_pkg::SHP_STANDBY);
		wr(7'h4B, 16'h0080);
		check(op_mode, shp_pkg::SHP_PROGRAM);
		rd(7'h4B, v);
		check(v, 32'h0080);
		wr(7'h06, 16'h0300);
		push(8);
		// Burst from 0x0F: second word lands on the mode register
		shp_host_model_inst.wdat[1] = 16'h0002;
		shp_host_model_inst.frame(7'h0F, 1'b1, 2, 0);
		check(op_mode, shp_pkg::SHP_NORMAL);
		nrm = 1'b1;
		repeat (30) push(2 * (1 + int'(lfsr[3:0])));
		check(fifo_int, flag);
		rd(7'h00, v);
		check(v, stat(cnt, flag));
		shp_host_model_inst.frame(7'h60, 1'b0, 4, 0);
		for (int i = 0; i < 4; i++) begin
			b = q.pop_front();
			check(shp_host_model_inst.rdat[i], {b, q.pop_front()});
		end
		cnt = cnt - 8;
		flag = 1'b0;
		check(fifo_int, 1'b0);
		rd(7'h00, v);
		check(v, stat(cnt, 1'b0));
		push(2);
		check(fifo_int, flag);
		wr(7'h00, 16'h00FF);
		check(fifo_int, 1'b0);
		wr(7'h00, 16'h80FF);
		cnt = 0;
		rd(7'h00, v);
		check(v, stat(0, 1'b0));
		shp_host_model_inst.wdat[0] = 16'h0000;
		shp_host_model_inst.frame(7'h10, 1'b1, 0, 8);
		check(op_mode, shp_pkg::SHP_NORMAL);
		wr(7'h10, 16'h0000);
		check(op_mode, shp_pkg::SHP_STANDBY);
		nrm = 1'b0;
		push(4);
		rd(7'h00, v);
		check(v, stat(cnt, 1'b0));
		wr(7'h10, 16'h0001);
		wr(7'h4B, 16'h0000);
		wr(7'h10, 16'h0000);
		check(op_mode, shp_pkg::SHP_PROGRAM);
		results();
	end
endmodule
